// ==== logic/aftc_defs.svh ====
`ifndef AFTC_DEFS_SVH
`define AFTC_DEFS_SVH

// Register byte addresses
`define AFTC_ADDR_EVENT_THR   8'hcc
`define AFTC_ADDR_GROUP1_THR  8'hd0
`define AFTC_ADDR_IRQ_STATUS  8'he0
`define AFTC_ADDR_IRQ_MASK    8'he4

// Counter field layout
`define AFTC_CNT_WIDTH        10
`define AFTC_CNT_SIGN_SRC     7
`define AFTC_CNT_RESET        10'h000
`define AFTC_REG_RESET        16'h0000

// Interrupt status and mask bit positions
`define AFTC_IRQ_BIT_EVENT    0
`define AFTC_IRQ_BIT_GROUP1   1
`define AFTC_IRQ_RESET        2'h0

`endif

// ==== logic/aftc_pkg.sv ====
package aftc_pkg;

   // Direction of one counter step
   typedef enum logic [1:0] {
      AFTC_STEP_HOLD = 2'b00,
      AFTC_STEP_DOWN = 2'b01,
      AFTC_STEP_UP   = 2'b10
   } aftc_step_type;

endpackage

// ==== logic/aftc_thr_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aftc_defs.svh"

module aftc_thr_counter
   import aftc_pkg::*;
#(
   parameter int WIDTH = 10
) (
   input  wire logic             i_mclk,
   input  wire logic             i_srst,
   input  wire logic             i_load,
   input  wire logic [WIDTH-1:0] i_load_value,
   input  wire logic             i_fifo_write,
   input  wire logic             i_fifo_read,
   output logic      [WIDTH-1:0] o_count,
   output logic                  o_hit_zero
);

   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             hit_zero;
   logic             next_hit_zero;
   aftc_step_type    step;

   ////////////////////////////////////////////////////////////////////////
   // Step selection and next count; both strobes together cancel out
   always_comb begin
      if (i_fifo_write && !i_fifo_read) begin
         step = AFTC_STEP_DOWN;  // [R3]
      end else if (i_fifo_read && !i_fifo_write) begin
         step = AFTC_STEP_UP;    // [R4]
      end else begin
         step = AFTC_STEP_HOLD;  // [R5]
      end
      next_hit_zero = 1'b0;
      unique case (step)
         AFTC_STEP_DOWN: next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};  // [R12]
         AFTC_STEP_UP:   next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
         AFTC_STEP_HOLD: next_count = count;
      endcase
      // A software load wins over a strobe in the same cycle
      if (i_load) begin
         next_count = i_load_value;
      end else if (step != AFTC_STEP_HOLD && next_count == '0) begin
         next_hit_zero = 1'b1;  // [R12]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         count    <= '0;
         hit_zero <= 1'b0;
      end else begin
         count    <= next_count;
         hit_zero <= next_hit_zero;
      end
   end

   assign o_count    = count;
   assign o_hit_zero = hit_zero;

endmodule
`default_nettype wire

// ==== logic/aftc_irq_bit.sv ====
`timescale 1ns/1ps
`default_nettype none

module aftc_irq_bit (
   input  wire logic i_mclk,
   input  wire logic i_srst,
   input  wire logic i_set,
   input  wire logic i_clear,
   output logic      o_flag
);

   logic flag;
   logic next_flag;

   ////////////////////////////////////////////////////////////////////////
   // Sticky flag; a set in the clearing cycle is kept so no event is lost
   always_comb begin
      next_flag = flag;
      if (i_clear) begin
         next_flag = 1'b0;
      end
      if (i_set) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end

   assign o_flag = flag;

endmodule
`default_nettype wire

// ==== logic/aftc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aftc_defs.svh"

// What this block does
// [R1] Software loads event counter before event conversions
// [R2] Software loads group 1 counter before conversions
// [R3] FIFO write decrements that group's counter
// [R4] FIFO read increments that group's counter
// [R5] Simultaneous read and write hold the counter
// [R6] Event counter reaching zero sets event flag
// [R7] Event interrupt requested only while enabled
// [R8] Group 1 zero sets flag, interrupts if enabled
// [R9] Bits 15..10 read-only, copy counter bit 7
// [R10] Counters behave same in every operating mode
// [R11] Negative count shows results beyond the threshold
// [R12] Ten-bit wrapping count, flag on entering zero
module aftc_top
   import aftc_pkg::*;
#(
   parameter int CNT_WIDTH = `AFTC_CNT_WIDTH
) (
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   input  wire logic [7:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [15:0] o_rdata,
   input  wire logic        i_event_fifo_write,
   input  wire logic        i_event_fifo_read,
   input  wire logic        i_group1_fifo_write,
   input  wire logic        i_group1_fifo_read,
   output logic             o_irq
);

   logic [CNT_WIDTH-1:0] event_threshold_count;
   logic [CNT_WIDTH-1:0] group1_threshold_count;
   logic                 event_zero;
   logic                 group1_zero;
   logic                 event_buffer_irq_flag;
   logic                 group1_buffer_irq_flag;
   logic [1:0]           irq_mask;
   logic [1:0]           next_irq_mask;
   logic [15:0]          rdata;
   logic [15:0]          next_rdata;
   logic                 irq;
   logic                 next_irq;
   logic                 load_event;
   logic                 load_group1;
   logic                 wr_status;
   logic [1:0]           status;

   ////////////////////////////////////////////////////////////////////////
   // Write decode; counters are writable whatever mode the converter is in
   assign load_event  = i_wr && (i_addr == `AFTC_ADDR_EVENT_THR);   // [R10]
   assign load_group1 = i_wr && (i_addr == `AFTC_ADDR_GROUP1_THR);  // [R10]
   assign wr_status   = i_wr && (i_addr == `AFTC_ADDR_IRQ_STATUS);

   ////////////////////////////////////////////////////////////////////////
   // Event group counter, preloaded by software before conversions
   aftc_thr_counter #(
      .WIDTH        (CNT_WIDTH)
   ) u_event_cnt (
      .i_mclk       (i_mclk),
      .i_srst       (i_srst),
      .i_load       (load_event),                       // [R1]
      .i_load_value (i_wdata[CNT_WIDTH-1:0]),
      .i_fifo_write (i_event_fifo_write),
      .i_fifo_read  (i_event_fifo_read),
      .o_count      (event_threshold_count),
      .o_hit_zero   (event_zero)
   );

   // Group 1 counter
   aftc_thr_counter #(
      .WIDTH        (CNT_WIDTH)
   ) u_group1_cnt (
      .i_mclk       (i_mclk),
      .i_srst       (i_srst),
      .i_load       (load_group1),                      // [R2]
      .i_load_value (i_wdata[CNT_WIDTH-1:0]),
      .i_fifo_write (i_group1_fifo_write),
      .i_fifo_read  (i_group1_fifo_read),
      .o_count      (group1_threshold_count),
      .o_hit_zero   (group1_zero)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sticky buffer flags, cleared by writing one
   aftc_irq_bit u_event_flag (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_set   (event_zero),                                             // [R6]
      .i_clear (wr_status && i_wdata[`AFTC_IRQ_BIT_EVENT]),
      .o_flag  (event_buffer_irq_flag)
   );

   aftc_irq_bit u_group1_flag (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_set   (group1_zero),                                            // [R8]
      .i_clear (wr_status && i_wdata[`AFTC_IRQ_BIT_GROUP1]),
      .o_flag  (group1_buffer_irq_flag)
   );

   always_comb begin
      status = 2'h0;
      status[`AFTC_IRQ_BIT_EVENT]  = event_buffer_irq_flag;
      status[`AFTC_IRQ_BIT_GROUP1] = group1_buffer_irq_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mask register and interrupt output; the output lags the flag by a cycle
   // so that it comes straight from a flip-flop
   always_comb begin
      next_irq_mask = irq_mask;
      if (i_wr && i_addr == `AFTC_ADDR_IRQ_MASK) begin
         next_irq_mask = i_wdata[1:0];
      end
      next_irq = |(status & irq_mask);  // [R7] [R8]
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux; upper counter bits mirror bit 7, reproducing the device as
   // built even though bit 9 would be the true sign. Unmapped reads give zero.
   always_comb begin
      next_rdata = 16'h0000;
      if (i_rd) begin
         unique case (i_addr)
            `AFTC_ADDR_EVENT_THR:
               next_rdata = {{(16-CNT_WIDTH){event_threshold_count[`AFTC_CNT_SIGN_SRC]}},
                             event_threshold_count};  // [R9] [R11]
            `AFTC_ADDR_GROUP1_THR:
               next_rdata = {{(16-CNT_WIDTH){group1_threshold_count[`AFTC_CNT_SIGN_SRC]}},
                             group1_threshold_count};  // [R9] [R11]
            `AFTC_ADDR_IRQ_STATUS: next_rdata = {14'h0000, status};
            `AFTC_ADDR_IRQ_MASK:   next_rdata = {14'h0000, irq_mask};
            default:               next_rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         irq_mask <= `AFTC_IRQ_RESET;
         irq      <= 1'b0;
         rdata    <= `AFTC_REG_RESET;
      end else begin
         irq_mask <= next_irq_mask;
         irq      <= next_irq;
         rdata    <= next_rdata;
      end
   end

   assign o_rdata = rdata;
   assign o_irq   = irq;

endmodule
`default_nettype wire

// ==== dv/aftc_chk_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aftc_defs.svh"
module aftc_chk (
   input wire logic        i_mclk,
   input wire logic        i_srst,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        i_event_fifo_write,
   input wire logic        i_event_fifo_read,
   input wire logic        i_group1_fifo_write,
   input wire logic        i_group1_fifo_read,
   input wire logic        o_irq
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   // A read and a write together cancel, so only a lone strobe can move a count
   wire logic ctr = i_addr == `AFTC_ADDR_EVENT_THR || i_addr == `AFTC_ADDR_GROUP1_THR;
   wire logic stat = i_rd && i_addr == `AFTC_ADDR_IRQ_STATUS;
   wire logic fx = (i_event_fifo_write ^ i_event_fifo_read) | (i_group1_fifo_write ^ i_group1_fifo_read);
   wire logic msk = i_addr == `AFTC_ADDR_IRQ_MASK;
   ////////////////////////////////////////////////////////////////////////////
   property p_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("read data outside answer cycle");
   property p_sign; i_rd && ctr |=> o_rdata[15:10] == {6{o_rdata[7]}}; endproperty
   a_sign: assert property (p_sign) else $error("upper bits differ from bit 7");
   property p_load; i_wr && ctr ##1 i_rd && i_addr == $past(i_addr) |=> o_rdata[9:0] == $past(i_wdata[9:0], 2);
   endproperty
   a_load: assert property (p_load) else $error("counter load not read back");
   property p_mask; i_wr && msk ##1 i_rd && msk |=> o_rdata[1:0] == $past(i_wdata[1:0], 2); endproperty
   a_mask: assert property (p_mask) else $error("mask not read back");
   property p_moff; i_wr && msk && i_wdata[1:0] == 2'h0 |=> ##1 !o_irq; endproperty
   a_moff: assert property (p_moff) else $error("irq with mask cleared");
   property p_rise; $rose(o_irq) |-> $past(i_wr, 2) || $past(fx, 3); endproperty
   a_rise: assert property (p_rise) else $error("irq rose without cause");
   property p_fall; $fell(o_irq) |-> $past(i_wr, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fell without clear");
   property p_stat; o_irq && stat && !$past(i_wr) |=> o_rdata[1:0] != 2'h0; endproperty
   a_stat: assert property (p_stat) else $error("irq with empty status");
   c_irq: cover property ($rose(o_irq));
   c_neg: cover property (i_rd && ctr ##1 o_rdata[9]);
   c_hold: cover property (i_event_fifo_write && i_event_fifo_read);
endmodule
bind aftc_top aftc_chk aftc_chk_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_event_fifo_write(i_event_fifo_write),
   .i_event_fifo_read(i_event_fifo_read), .i_group1_fifo_write(i_group1_fifo_write),
   .i_group1_fifo_read(i_group1_fifo_read), .o_irq(o_irq));
`default_nettype wire

// ==== dv/aftc_fifo_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module aftc_fifo_model (
   input  wire logic i_mclk,
   output logic      o_ev_wr,
   output logic      o_ev_rd,
   output logic      o_g1_wr,
   output logic      o_g1_rd
);
   // Strobes idle from time zero
   initial begin
      {o_g1_wr, o_ev_wr} = 2'h0;
      {o_g1_rd, o_ev_rd} = 2'h0;
   end
   // One pulse, then a quiet cycle so two calls never collide
   task automatic step(input logic [1:0] w, input logic [1:0] r);
      {o_g1_wr, o_ev_wr} <= w;
      {o_g1_rd, o_ev_rd} <= r;
      @(posedge i_mclk);
      {o_g1_wr, o_ev_wr} <= 2'h0;
      {o_g1_rd, o_ev_rd} <= 2'h0;
      @(posedge i_mclk);
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_adc_fifo_threshold_counters.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aftc_defs.svh"
module tb_adc_fifo_threshold_counters;
   logic        i_mclk = 1'b0;
   logic        i_srst = 1'b1;
   logic [7:0]  i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        rd_seen = 1'b0;
   logic [15:0] v;
   logic [15:0] exp_q[$];
   wire logic [15:0] o_rdata;
   wire logic   o_irq, ev_w, ev_r, g1_w, g1_r;
   int          err_count = 0;
   int          checked = 0;
   aftc_top aftc_top_i (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_event_fifo_write(ev_w), .i_event_fifo_read(ev_r),
      .i_group1_fifo_write(g1_w), .i_group1_fifo_read(g1_r), .o_irq(o_irq));
   aftc_fifo_model aftc_fifo_model_i (.i_mclk(i_mclk), .o_ev_wr(ev_w), .o_ev_rd(ev_r), .o_g1_wr(g1_w),
      .o_g1_rd(g1_r));
   initial forever #12.5 i_mclk = ~i_mclk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] cnt_word(input logic [9:0] c);
      return {{6{c[7]}}, c};
   endfunction
   task automatic check(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Strobe stays up for back-to-back calls; a read notes its expected data
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
      i_wr <= w;
      i_rd <= !w;
      i_addr <= a;
      i_wdata <= d;
      if (!w) exp_q.push_back(d);
      @(posedge i_mclk);
   endtask
   task automatic idle(input int n);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      repeat (n) @(posedge i_mclk);
   endtask
   // Count down to zero masked, unmask, go negative, come back, clear
   task automatic run(input int g);
      logic [7:0] a;
      logic [15:0] m;
      a = g ? `AFTC_ADDR_GROUP1_THR : `AFTC_ADDR_EVENT_THR;
      m = 16'h0001 << g;
      bus(1, `AFTC_ADDR_IRQ_MASK, 16'h0000);
      bus(1, a, 16'h0002);
      idle(1);
      aftc_fifo_model_i.step(m[1:0], m[1:0]);
      aftc_fifo_model_i.step(m[1:0], 2'h0);
      bus(0, a, 16'h0001);
      idle(1);
      aftc_fifo_model_i.step(m[1:0], 2'h0);
      idle(3);
      check(o_irq === 1'b0, "masked irq");
      bus(0, `AFTC_ADDR_IRQ_STATUS, m);
      bus(1, `AFTC_ADDR_IRQ_MASK, m);
      bus(0, `AFTC_ADDR_IRQ_MASK, m);
      idle(3);
      check(o_irq === 1'b1, "irq");
      bus(0, `AFTC_ADDR_IRQ_STATUS, m);
      idle(1);
      aftc_fifo_model_i.step(m[1:0], 2'h0);
      bus(0, a, cnt_word(10'h3ff));
      idle(1);
      aftc_fifo_model_i.step(2'h0, m[1:0]);
      bus(0, a, 16'h0000);
      bus(1, `AFTC_ADDR_IRQ_STATUS, m);
      idle(3);
      check(o_irq === 1'b0, "irq after clear");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Compare each read answer with the oldest note
   always @(posedge i_mclk) begin
      rd_seen <= i_rd;
      if (rd_seen) check(exp_q.size() > 0 && o_rdata === exp_q.pop_front(), "read data");
   end
   initial begin
      repeat (5000) @(posedge i_mclk);
      check(1'b0, "timeout");
      end_sim();
   end
   initial begin
      void'($urandom(32'h6e009973));
      repeat (20) @(posedge i_mclk);
      i_srst <= 1'b0;
      bus(0, `AFTC_ADDR_EVENT_THR, 16'h0000);
      bus(0, `AFTC_ADDR_GROUP1_THR, 16'h0000);
      bus(0, `AFTC_ADDR_IRQ_MASK, 16'h0000);
      bus(0, 8'h10, 16'h0000);
      v = 16'($urandom());
      bus(1, `AFTC_ADDR_GROUP1_THR, v);
      bus(0, `AFTC_ADDR_GROUP1_THR, cnt_word(v[9:0]));
      for (int g = 0; g < 2; g++) begin
         run(g);
      end
      idle(4);
      end_sim();
   end
endmodule
`default_nettype wire
